/* File: gtc_top.sv */
// gated 16-bit timer/counter with APB register file and interrupt
// ****************************************************************
// Notes on behaviour
// - sixteen-bit counter, interval timer or time base
// - timer and external counter modes, both counter paths synchronised
// - interrupt on period match or gate fall
// - source select and gate enable bits
// - two-bit prescale select divides counting clock
// - sync select bit picks between two equally synchronised external clock paths
// - counter runs only while module on set
// - loadable period value compared with count
// - irq forwarded when enabled, three-bit priority
// - keeps counting during cpu idle and sleep
// ****************************************************************
`timescale 1ns/1ps
module gtc_top (
   input  wire logic        mclk_i,       // system clock, 100 MHz
   input  wire logic        resetn_i,     // async reset, active low
   input  wire logic        ce_i,         // clock enable, freezes registers, counter and irq
   input  wire logic        ext_clk_i,    // external counting clock pin
   input  wire logic        gate_i,       // external gate pin
   input  wire logic        cpu_idle_i,   // cpu idle indication
   input  wire logic        cpu_sleep_i,  // cpu sleep indication
   input  wire logic        psel_i,       // apb select
   input  wire logic        penable_i,    // apb enable
   input  wire logic        pwrite_i,     // apb write
   input  wire logic [7:0]  paddr_i,      // apb address
   input  wire logic [31:0] pwdata_i,     // apb write data
   input  wire logic [3:0]  pstrb_i,      // apb byte strobes
   output logic      [31:0] prdata_o,     // apb read data
   output logic             pready_o,     // apb ready
   output logic             pslverr_o,    // apb error
   output logic             irq_o,        // interrupt level
   output logic      [2:0]  irq_prio_o    // interrupt priority
);
   localparam int NE = gtc_pkg::NUM_EVENTS;
   logic        rst_s1_reg;
   logic        rst_n;
   logic        ext_s1_reg;
   logic        ext_s2_reg;
   logic        gate_s1_reg;
   logic        gate_s2_reg;
   logic [15:0] ctrl_reg;
   logic [15:0] period_reg;
   logic [NE-1:0] stat_reg;
   logic [NE-1:0] mask_reg;
   logic [2:0]  prio_reg;
   logic        wr_en;
   logic        rd_en;
   logic        hit;
   logic [31:0] rd_next;
   logic [NE-1:0] ev;
   logic        cnt_wr;

   gtc_if cif ();

   // ****************************************************************
   // reset release and pin synchronisers
   // ****************************************************************
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_s1_reg <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n      <= rst_s1_reg;
      end
   end

   // pins are sampled always so levels stay current across ce_i low
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ext_s1_reg  <= 1'b0;
         ext_s2_reg  <= 1'b0;
         gate_s1_reg <= 1'b0;
         gate_s2_reg <= 1'b0;
      end else begin
         ext_s1_reg  <= ext_clk_i;
         ext_s2_reg  <= ext_s1_reg;
         gate_s1_reg <= gate_i;
         gate_s2_reg <= gate_s1_reg;
      end
   end

   // ****************************************************************
   // apb decode
   // ****************************************************************
   assign wr_en     = psel_i && penable_i && pwrite_i;
   assign rd_en     = psel_i && !pwrite_i;
   assign pready_o  = 1'b1;
   assign hit       = (paddr_i == gtc_pkg::CTRL_OFS)  || (paddr_i == gtc_pkg::PERIOD_OFS) ||
                      (paddr_i == gtc_pkg::COUNT_OFS) || (paddr_i == gtc_pkg::STAT_OFS)   ||
                      (paddr_i == gtc_pkg::MASK_OFS)  || (paddr_i == gtc_pkg::PRIO_OFS);
   assign pslverr_o = psel_i && penable_i && !hit;
   assign cnt_wr    = wr_en && ce_i && (paddr_i == gtc_pkg::COUNT_OFS) && pstrb_i[0];

   // ****************************************************************
   // control registers
   // ****************************************************************
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= 16'h0000;
      end else if (ce_i && wr_en && paddr_i == gtc_pkg::CTRL_OFS) begin
         if (pstrb_i[0]) ctrl_reg[7:0]  <= pwdata_i[7:0] & gtc_pkg::CTRL_WMASK[7:0];
         if (pstrb_i[1]) ctrl_reg[15:8] <= pwdata_i[15:8] & gtc_pkg::CTRL_WMASK[15:8];
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         period_reg <= gtc_pkg::PERIOD_RST;
      end else if (ce_i && wr_en && paddr_i == gtc_pkg::PERIOD_OFS) begin
         if (pstrb_i[0]) period_reg[7:0]  <= pwdata_i[7:0];
         if (pstrb_i[1]) period_reg[15:8] <= pwdata_i[15:8];
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         mask_reg <= '0;
         prio_reg <= gtc_pkg::PRIO_RST;
      end else if (ce_i && wr_en && pstrb_i[0]) begin
         if (paddr_i == gtc_pkg::MASK_OFS) mask_reg <= pwdata_i[NE-1:0];
         if (paddr_i == gtc_pkg::PRIO_OFS) prio_reg <= pwdata_i[2:0];
      end
   end

   assign cif.run       = ctrl_reg[gtc_pkg::CTRL_ON_BIT];
   assign cif.cs_ext    = ctrl_reg[gtc_pkg::CTRL_CS_BIT];
   assign cif.sync_sel  = ctrl_reg[gtc_pkg::CTRL_SYNC_BIT];
   assign cif.gate_en   = ctrl_reg[gtc_pkg::CTRL_GATE_BIT];
   assign cif.ps_sel    = ctrl_reg[gtc_pkg::CTRL_PS_HI:gtc_pkg::CTRL_PS_LO];
   assign cif.period    = period_reg;
   assign cif.cnt_wr    = cnt_wr;
   assign cif.cnt_wdata = pwdata_i[15:0];

   // ****************************************************************
   // counting core
   // ****************************************************************
   // cpu_idle_i and cpu_sleep_i are deliberately not used to stop it
   gtc_core #(.CW(16)) u_core (
      .mclk_i      (mclk_i),
      .rst_n       (rst_n),
      .ce_i        (ce_i),
      .ext_clk_s   (ext_s2_reg),
      .ext_clk_raw (ext_s2_reg),
      .gate_s      (gate_s2_reg),
      .c           (cif)
   );

   // ****************************************************************
   // interrupt status
   // ****************************************************************
   assign ev[gtc_pkg::ST_MATCH_BIT] = cif.match_ev;
   assign ev[gtc_pkg::ST_GATE_BIT]  = cif.gate_ev;

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         stat_reg <= '0;
      end else if (ce_i) begin
         // a new event wins over a write-one clear
         if (wr_en && paddr_i == gtc_pkg::STAT_OFS && pstrb_i[0]) begin
            stat_reg <= (stat_reg & ~pwdata_i[NE-1:0]) | ev;
         end else begin
            stat_reg <= stat_reg | ev;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_o      <= 1'b0;
         irq_prio_o <= 3'h0;
      end else if (ce_i) begin
         irq_o      <= ctrl_reg[gtc_pkg::CTRL_IE_BIT] && (prio_reg != 3'h0) &&
                       |(stat_reg & mask_reg);
         irq_prio_o <= prio_reg;
      end
   end

   // ****************************************************************
   // read data
   // ****************************************************************
   always_comb begin
      rd_next = gtc_pkg::RD_ZERO;
      unique case (paddr_i)
         gtc_pkg::CTRL_OFS:   rd_next[15:0]   = ctrl_reg;
         gtc_pkg::PERIOD_OFS: rd_next[15:0]   = period_reg;
         gtc_pkg::COUNT_OFS:  rd_next[15:0]   = cif.count;
         gtc_pkg::STAT_OFS:   rd_next[NE-1:0] = stat_reg;
         gtc_pkg::MASK_OFS:   rd_next[NE-1:0] = mask_reg;
         gtc_pkg::PRIO_OFS:   rd_next[2:0]    = prio_reg;
         default:             rd_next         = gtc_pkg::RD_ZERO;
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         prdata_o <= gtc_pkg::RD_ZERO;
      end else if (rd_en && !penable_i) begin
         prdata_o <= rd_next;
      end
   end
endmodule : gtc_top

/* File: gtc_pkg.sv */
// package with register map, field layout and constants of the gated counter
package gtc_pkg;
   // ****************************************************************
   // register byte offsets
   // ****************************************************************
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] PERIOD_OFS = 8'h04;
   localparam logic [7:0] COUNT_OFS  = 8'h08;
   localparam logic [7:0] STAT_OFS   = 8'h0C;
   localparam logic [7:0] MASK_OFS   = 8'h10;
   localparam logic [7:0] PRIO_OFS   = 8'h14;
   // ****************************************************************
   // control field positions
   // ****************************************************************
   localparam int CTRL_ON_BIT     = 15;
   localparam int CTRL_GATE_BIT   = 6;
   localparam int CTRL_PS_HI      = 5;
   localparam int CTRL_PS_LO      = 4;
   localparam int CTRL_SYNC_BIT   = 2;
   localparam int CTRL_CS_BIT     = 1;
   localparam int CTRL_IE_BIT     = 0;
   localparam logic [15:0] CTRL_WMASK = 16'h8077;
   // ****************************************************************
   // status bits and widths
   // ****************************************************************
   localparam int ST_MATCH_BIT  = 0;
   localparam int ST_GATE_BIT   = 1;
   localparam int NUM_EVENTS    = 2;
   localparam int PRIO_W        = 3;
   localparam logic [15:0] PERIOD_RST = 16'hFFFF;
   localparam logic [2:0]  PRIO_RST   = 3'h4;
   localparam logic [31:0] RD_ZERO    = 32'h0000_0000;
   typedef enum logic [1:0] {GTC_DIV1, GTC_DIV8, GTC_DIV64, GTC_DIV256} gtc_ps_t;
endpackage : gtc_pkg

/* File: gtc_if.sv */
// interface carrying counting controls from the register file to the core
`timescale 1ns/1ps
interface gtc_if;
   logic        run;      // module on
   logic        cs_ext;   // external clock source
   logic        sync_sel; // synchronised external counting
   logic        gate_en;  // gated accumulation
   logic [1:0]  ps_sel;   // prescale select
   logic [15:0] period;   // period value
   logic        cnt_wr;   // software write of count
   logic [15:0] cnt_wdata;
   logic [15:0] count;    // current count
   logic        match_ev; // period match pulse
   logic        gate_ev;  // gate falling edge pulse
   modport ctl  (output run, cs_ext, sync_sel, gate_en, ps_sel, period, cnt_wr, cnt_wdata,
                 input count, match_ev, gate_ev);
   modport core (input run, cs_ext, sync_sel, gate_en, ps_sel, period, cnt_wr, cnt_wdata,
                 output count, match_ev, gate_ev);
endinterface : gtc_if

/* File: gtc_core.sv */
// counting core: prescaler, gate, period match and restart
`timescale 1ns/1ps
module gtc_core #(
   parameter int CW = 16
) (
   input  wire logic mclk_i,     // system clock
   input  wire logic rst_n,      // synchronised reset, active low
   input  wire logic ce_i,       // clock enable
   input  wire logic ext_clk_s,  // external clock, already synchronised
   input  wire logic ext_clk_raw,// external clock, sync_sel low path, same two-stage sample
   input  wire logic gate_s,     // gate input, already synchronised
   gtc_if.core       c           // controls and events
);
   logic [7:0]  pre_reg;
   logic        ext_q_reg;
   logic        gate_q_reg;
   logic        tick;
   logic        src_tick;
   logic        pre_tick;
   logic        ext_rise;
   logic [CW-1:0] cnt_reg;
   logic        wrap_reg;

   function automatic logic [7:0] ps_limit(input logic [1:0] s);
      unique case (gtc_pkg::gtc_ps_t'(s))
         gtc_pkg::GTC_DIV1:   ps_limit = 8'h00;
         gtc_pkg::GTC_DIV8:   ps_limit = 8'h07;
         gtc_pkg::GTC_DIV64:  ps_limit = 8'h3F;
         gtc_pkg::GTC_DIV256: ps_limit = 8'hFF;
      endcase
   endfunction : ps_limit

   // ****************************************************************
   // source selection and edge detect
   // ****************************************************************
   // both paths share the two-stage sample: there is no second clock
   // domain, so the sync bit only selects between equal timings
   assign ext_rise = c.sync_sel ? (ext_clk_s & ~ext_q_reg) : (ext_clk_raw & ~ext_q_reg);
   assign src_tick = c.cs_ext ? ext_rise : 1'b1;
   assign pre_tick = src_tick && (pre_reg == ps_limit(c.ps_sel));
   assign tick = c.run && pre_tick && (!c.gate_en || gate_s);

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ext_q_reg  <= 1'b0;
         gate_q_reg <= 1'b0;
      end else if (ce_i) begin
         ext_q_reg  <= c.sync_sel ? ext_clk_s : ext_clk_raw;
         gate_q_reg <= gate_s;
      end
   end

   // ****************************************************************
   // prescaler
   // ****************************************************************
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         pre_reg <= 8'h00;
      end else if (ce_i) begin
         if (!c.run || c.cnt_wr) begin
            pre_reg <= 8'h00;
         end else if (src_tick) begin
            pre_reg <= pre_tick ? 8'h00 : pre_reg + 8'h01;
         end
      end
   end

   // ****************************************************************
   // counter with period restart
   // ****************************************************************
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg  <= '0;
         wrap_reg <= 1'b0;
      end else if (ce_i) begin
         if (c.cnt_wr) begin
            cnt_reg  <= c.cnt_wdata;
            wrap_reg <= 1'b0;
         end else if (tick) begin
            if (wrap_reg) begin
               cnt_reg  <= '0;
               wrap_reg <= 1'b0;
            end else begin
               cnt_reg  <= cnt_reg + 1'b1;
               wrap_reg <= ((cnt_reg + 1'b1) == c.period);
            end
         end
      end
   end

   assign c.count    = cnt_reg;
   assign c.match_ev = ce_i && tick && !wrap_reg && ((cnt_reg + 1'b1) == c.period);
   assign c.gate_ev  = ce_i && c.run && c.gate_en && gate_q_reg && !gate_s;
endmodule : gtc_core

/* File: gtc_monitor.sv */
// port checker of the gated counter
`timescale 1ns/1ps
module gtc_monitor (
   input wire logic        mclk_i,     // clock
   input wire logic        resetn_i,   // reset, active low
   input wire logic        ce_i,       // clock enable
   input wire logic        psel_i,     // apb select
   input wire logic        penable_i,  // apb enable
   input wire logic        pwrite_i,   // apb write
   input wire logic [7:0]  paddr_i,    // apb address
   input wire logic [31:0] pwdata_i,   // apb write data
   input wire logic [3:0]  pstrb_i,    // apb strobes
   input wire logic        pready_o,   // apb ready
   input wire logic        pslverr_o,  // apb error
   input wire logic        irq_o,      // interrupt
   input wire logic [2:0]  irq_prio_o  // priority
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   logic       acc;
   logic       wr;
   logic       hit;
   logic [2:0] wprio;
   assign acc   = psel_i && penable_i;
   assign wr    = acc && pwrite_i && ce_i && pstrb_i[0];
   assign wprio = pwdata_i[2:0];
   assign hit   = paddr_i inside {gtc_pkg::CTRL_OFS, gtc_pkg::PERIOD_OFS, gtc_pkg::COUNT_OFS,
                                  gtc_pkg::STAT_OFS, gtc_pkg::MASK_OFS, gtc_pkg::PRIO_OFS};
   property p_prio_wr;
      wr && paddr_i == gtc_pkg::PRIO_OFS |-> ##2 irq_prio_o == $past(wprio, 2);
   endproperty
   a_prio_wr: assert property (p_prio_wr) else $error("priority pin not updated");
   property p_prio_zero;
      (irq_prio_o == 3'h0) [*2] |-> !irq_o;
   endproperty
   a_prio_zero: assert property (p_prio_zero) else $error("irq at priority zero");
   property p_irq_rise;
      $rose(irq_o) |-> irq_prio_o != 3'h0;
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq rose while disabled");
   property p_ie_off;
      wr && paddr_i == gtc_pkg::CTRL_OFS && !pwdata_i[0] |-> ##[2:3] !irq_o;
   endproperty
   a_ie_off: assert property (p_ie_off) else $error("irq kept after enable off");
   property p_mask_off;
      wr && paddr_i == gtc_pkg::MASK_OFS && pwdata_i[1:0] == 2'h0 |-> ##[2:3] !irq_o;
   endproperty
   a_mask_off: assert property (p_mask_off) else $error("irq kept after mask off");
   property p_unmapped;
      acc && !hit |-> pslverr_o;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("no error on unmapped access");
   property p_mapped;
      acc && hit |-> pready_o && !pslverr_o;
   endproperty
   a_mapped: assert property (p_mapped) else $error("bad answer on mapped access");
   property p_quiet;
      $rose(resetn_i) |-> !irq_o [*3];
   endproperty
   a_quiet: assert property (p_quiet) else $error("irq right after reset");
endmodule : gtc_monitor

/* File: gtc_src_model.sv */
// external counting clock and gate source
`timescale 1ns/1ps
module gtc_src_model (
   input  wire logic mclk_i,    // system clock
   output logic      ext_clk_o, // counting clock pin
   output logic      gate_o     // gate pin
);
   initial begin
      ext_clk_o = 1'b0;
      gate_o    = 1'b0;
   end
   // clock idles low between bursts, each level held half clocks
   task automatic burst(input int n, input int half);
      for (int i = 0; i < 2 * n; i++) begin
         @(posedge mclk_i);
         ext_clk_o <= ~ext_clk_o;
         repeat (half - 1) @(posedge mclk_i);
      end
   endtask : burst
   task automatic gate_pulse(input int hold);
      @(posedge mclk_i);
      gate_o <= 1'b1;
      repeat (hold) @(posedge mclk_i);
      gate_o <= 1'b0;
   endtask : gate_pulse
endmodule : gtc_src_model

/* File: tb_top.sv */
// testbench of the gated counter
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin num_errors++; \
   $display("Error %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
   logic mclk_i, resetn_i, ce_i, ext_clk_i, gate_i, cpu_idle_i, cpu_sleep_i;
   logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o, er;
   logic [7:0]  paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic [3:0]  pstrb_i;
   logic [2:0]  irq_prio_o;
   int          num_errors, n_compared;
   gtc_top gtc_top_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i), .ext_clk_i(ext_clk_i),
      .gate_i(gate_i), .cpu_idle_i(cpu_idle_i), .cpu_sleep_i(cpu_sleep_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .irq_o(irq_o), .irq_prio_o(irq_prio_o));
   gtc_src_model gtc_src_model_i (.mclk_i(mclk_i), .ext_clk_o(ext_clk_i), .gate_o(gate_i));
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   task automatic end_sim;
      if (num_errors == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      psel_i    <= 1'b1;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      @(posedge mclk_i);
      while (pready_o !== 1'b1) @(posedge mclk_i);
      rd = prdata_o;
      er = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [15:0] ex, input string nm);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(nm, ex, rd[15:0])
   endtask : rchk
   task automatic t_regs;
      rchk(gtc_pkg::CTRL_OFS, 16'h0000, "ctrl");
      rchk(gtc_pkg::PERIOD_OFS, gtc_pkg::PERIOD_RST, "period");
      rchk(gtc_pkg::COUNT_OFS, 16'h0000, "count");
      rchk(gtc_pkg::STAT_OFS, 16'h0000, "status");
      rchk(gtc_pkg::PRIO_OFS, {13'h0000, gtc_pkg::PRIO_RST}, "prio");
      `CHK("prio pin", gtc_pkg::PRIO_RST, irq_prio_o)
      apb(1'b0, 8'h18, 32'h0000_0000);
      `CHK("unmapped err", 1'b1, er)
      `CHK("unmapped data", gtc_pkg::RD_ZERO, rd)
      wr(gtc_pkg::PERIOD_OFS, 32'h0000_1234);
      rchk(gtc_pkg::PERIOD_OFS, 16'h1234, "period load");
   endtask : t_regs
   task automatic t_timer;
      logic [15:0] c;
      wr(gtc_pkg::COUNT_OFS, 32'h0000_0000);
      wr(gtc_pkg::PERIOD_OFS, 32'h0000_0003);
      wr(gtc_pkg::MASK_OFS, 32'h0000_0001);
      wr(gtc_pkg::CTRL_OFS, 32'h0000_8001);
      for (int i = 0; i < 100 && irq_o !== 1'b1; i++) @(posedge mclk_i);
      `CHK("match irq", 1'b1, irq_o)
      apb(1'b0, gtc_pkg::COUNT_OFS, 32'h0000_0000);
      `CHK("count wraps", 1'b1, rd[15:0] <= 16'h0003)
      rchk(gtc_pkg::STAT_OFS, 16'h0001, "match event");
      wr(gtc_pkg::CTRL_OFS, 32'h0000_0000);
      repeat (4) @(posedge mclk_i);
      `CHK("irq disabled", 1'b0, irq_o)
      wr(gtc_pkg::STAT_OFS, 32'h0000_0001);
      rchk(gtc_pkg::STAT_OFS, 16'h0000, "status cleared");
      apb(1'b0, gtc_pkg::COUNT_OFS, 32'h0000_0000);
      c = rd[15:0];
      repeat (20) @(posedge mclk_i);
      rchk(gtc_pkg::COUNT_OFS, c, "stopped count");
   endtask : t_timer
   task automatic t_psc;
      int dv[4] = '{1, 8, 64, 256};
      int c;
      cpu_idle_i  <= 1'b1;
      cpu_sleep_i <= 1'b1;
      for (int p = 0; p < 4; p++) begin
         wr(gtc_pkg::PERIOD_OFS, 32'h0000_FFFF);
         wr(gtc_pkg::COUNT_OFS, 32'h0000_0000);
         wr(gtc_pkg::CTRL_OFS, 32'h0000_8000 | (32'(p) << 4));
         repeat (512) @(posedge mclk_i);
         apb(1'b0, gtc_pkg::COUNT_OFS, 32'h0000_0000);
         c = 512 / dv[p];
         `CHK("prescaled count", 1'b1, rd[15:0] >= c - 1 && rd[15:0] <= c + 4)
         wr(gtc_pkg::CTRL_OFS, 32'h0000_0000);
      end
      cpu_idle_i  <= 1'b0;
      cpu_sleep_i <= 1'b0;
   endtask : t_psc
   task automatic t_ext;
      for (int s = 0; s < 2; s++) begin
         wr(gtc_pkg::COUNT_OFS, 32'h0000_0000);
         wr(gtc_pkg::CTRL_OFS, 32'h0000_8002 | (32'(s) << 2));
         gtc_src_model_i.burst(5, 4);
         repeat (8) @(posedge mclk_i);
         rchk(gtc_pkg::COUNT_OFS, 16'h0005, "external count");
         wr(gtc_pkg::CTRL_OFS, 32'h0000_0000);
      end
   endtask : t_ext
   task automatic t_gate;
      wr(gtc_pkg::COUNT_OFS, 32'h0000_0000);
      wr(gtc_pkg::MASK_OFS, 32'h0000_0002);
      wr(gtc_pkg::CTRL_OFS, 32'h0000_8041);
      repeat (10) @(posedge mclk_i);
      rchk(gtc_pkg::COUNT_OFS, 16'h0000, "gate closed");
      gtc_src_model_i.gate_pulse(30);
      repeat (10) @(posedge mclk_i);
      apb(1'b0, gtc_pkg::COUNT_OFS, 32'h0000_0000);
      `CHK("gated count", 1'b1, rd[15:0] >= 16'd26 && rd[15:0] <= 16'd34)
      rchk(gtc_pkg::STAT_OFS, 16'h0002, "gate event");
      `CHK("gate irq", 1'b1, irq_o)
      wr(gtc_pkg::PRIO_OFS, 32'h0000_0000);
      repeat (4) @(posedge mclk_i);
      `CHK("prio off irq", 1'b0, irq_o)
      `CHK("prio off pin", 3'h0, irq_prio_o)
      wr(gtc_pkg::PRIO_OFS, 32'h0000_0006);
      repeat (4) @(posedge mclk_i);
      `CHK("prio on irq", 1'b1, irq_o)
      `CHK("prio on pin", 3'h6, irq_prio_o)
      wr(gtc_pkg::MASK_OFS, 32'h0000_0000);
   endtask : t_gate
   initial begin
      {resetn_i, psel_i, penable_i, pwrite_i, cpu_idle_i, cpu_sleep_i} = 6'h00;
      ce_i     = 1'b1;
      paddr_i  = 8'h00;
      pwdata_i = 32'h0000_0000;
      pstrb_i  = 4'hF;
      repeat (20) @(posedge mclk_i);
      resetn_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      t_regs();
      t_timer();
      t_psc();
      t_ext();
      t_gate();
      end_sim();
   end
   initial begin
      repeat (20000) @(posedge mclk_i);
      num_errors++;
      end_sim();
   end
endmodule : tb_top
bind gtc_top gtc_monitor gtc_monitor_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .irq_o(irq_o), .irq_prio_o(irq_prio_o));
